/* File: design/sltc_top.sv */
// Purpose: Line driver, receiver gating and hold timing for a serial port
// Assumes: External shifter on CLK raises TXS_BUSY the cycle after TXS_START
// Notes:   Receive queue sized at run time, stored in on-chip array
// Functional notes
// [RULE1] Full duplex keeps the receiver enabled, even while sending.
// [RULE2] Differential standard: RTS and data drivers on from send to hold end.
// [RULE3] Differential standard: drivers high impedance outside send plus hold.
// [RULE4] Half duplex turns receiver off from send start to hold end.
// [RULE5] Hold counted in ms from last character end; default zero.
// [RULE6] Output completion reported only once the hold has expired.
// [RULE7] Queue takes one character fewer than its size before overflow.
// [RULE8] After overflow further characters are dropped and flagged.
// [RULE9] Queue size from 64 to 32750, storage bound, default 320.
// [RULE10] Point-to-point: receiver always on, differential drivers always on.
// [RULE11] Hardware flow: raise RTS, send after CTS, RTS held through hold.
// [RULE12] Software or no flow: RTS stays off, sending starts at once.
// [RULE13] Wiring codes half, full, point-to-point; full duplex after reset.
// [RULE14] Millisecond tick from clock; new character during hold cancels it.
// [RULE15] RS-232 leaves differential enables off, keeps gating and hold.
//
// Our own choices: the address map and the APB slave port.
`default_nettype none
module sltc_top
  import sltc_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  output var  logic        IRQ,
  output var  logic        TXS_START,
  output var  logic [7:0]  TXS_DATA,
  input  wire logic        TXS_BUSY,
  input  wire logic        RXS_VALID,
  input  wire logic [7:0]  RXS_DATA,
  input  wire logic        CTS_I,
  output var  logic        RTS_O,
  output var  logic        RTS_OE_N,
  output var  logic        TXD_OE_N,
  output var  logic        RX_EN
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  sltc_state_e           state_q, state_d;
  logic [1:0]            duplex_q, phys_q, flow_q;
  logic [15:0]           hold_q, hold_cnt_q;
  logic [14:0]           qsize_q;
  logic [IRQ_W-1:0]      int_stat_q, int_mask_q, ev;
  logic [7:0]            pend_data_q;
  logic                  pend_q, start_q;
  logic                  cts_m_q, cts_s_q;
  logic                  ms_tick, hold_clr, hold_done, tx_done_p;
  logic                  setup, access, wr, rd;
  logic                  tx_wr, rx_rd, ctrl_wr, qsize_wr, ist_rd;
  logic                  bad_addr;
  logic [31:0]           rdata_d;
  logic [7:0]            mem [QSIZE_STORE];
  logic [QPTR_W-1:0]     wp_q, rp_q, lim;
  logic [14:0]           cnt_q;
  logic                  q_full, q_empty, push, pop, ovf_ev;
  logic                  diff, active;
  logic [14:0]           qsize_clip;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign setup   = PSEL && !PENABLE;
  assign access  = PSEL && PENABLE;
  assign wr      = access && PWRITE;
  assign rd      = access && !PWRITE;
  assign tx_wr   = wr && (PADDR == ADDR_TXDATA) && !pend_q;
  assign ctrl_wr = wr && (PADDR == ADDR_CTRL);
  assign qsize_wr = wr && (PADDR == ADDR_QSIZE);
  assign rx_rd   = rd && (PADDR == ADDR_RXDATA);
  assign ist_rd  = rd && (PADDR == ADDR_INT_STAT);
  assign PREADY  = 1'b1;

  always_comb begin
    bad_addr = 1'b0;
    unique case (PADDR)
      ADDR_CTRL, ADDR_HOLD, ADDR_QSIZE, ADDR_RXDATA, ADDR_STATUS,
      ADDR_INT_STAT, ADDR_INT_MASK: bad_addr = 1'b0;
      ADDR_TXDATA: bad_addr = !PWRITE ? 1'b0 : pend_q;
      default: bad_addr = 1'b1;
    endcase
  end
  // Error only in the access phase, where APB samples it
  assign PSLVERR = access && bad_addr;

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (PADDR)
      ADDR_CTRL:     rdata_d = {26'h0, flow_q, phys_q, duplex_q};
      ADDR_HOLD:     rdata_d = {16'h0, hold_q};
      ADDR_QSIZE:    rdata_d = {17'h0, qsize_q};
      ADDR_RXDATA:   rdata_d = {24'h0, mem[rp_q]};
      ADDR_STATUS:   rdata_d = {14'h0, cnt_q, pend_q, state_q};
      ADDR_INT_STAT: rdata_d = {29'h0, int_stat_q};
      ADDR_INT_MASK: rdata_d = {29'h0, int_mask_q};
      default:       rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup so PRDATA comes from a flip-flop
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      duplex_q <= DUPLEX_FULL; // RULE13
      phys_q   <= PHYS_232;
      flow_q   <= FLOW_HW;
    end else if (ctrl_wr) begin
      duplex_q <= PWDATA[CTRL_DUPLEX_LSB +: 2];
      phys_q   <= PWDATA[CTRL_PHYS_LSB +: 2];
      flow_q   <= PWDATA[CTRL_FLOW_LSB +: 2];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_q <= HOLD_RST; // RULE5
    end else if (wr && (PADDR == ADDR_HOLD)) begin
      hold_q <= PWDATA[15:0];
    end
  end

  // Clip to range and to what the array can hold
  always_comb begin
    qsize_clip = PWDATA[14:0];
    if (PWDATA[14:0] < QSIZE_MIN) begin
      qsize_clip = QSIZE_MIN;
    end else if (PWDATA[14:0] > QSIZE_MAX ||
                 PWDATA[14:0] > QSIZE_STORE) begin
      qsize_clip = QSIZE_STORE; // RULE9
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      qsize_q <= QSIZE_RST; // RULE9
    end else if (qsize_wr) begin
      qsize_q <= qsize_clip;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      int_mask_q <= '0;
    end else if (wr && (PADDR == ADDR_INT_MASK)) begin
      int_mask_q <= PWDATA[IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign ev[IRQ_TX_DONE] = tx_done_p;
  assign ev[IRQ_RX_CHAR] = push;
  assign ev[IRQ_RX_OVF]  = ovf_ev;

  // Clear only what the read returned; later events are not lost
  always_ff @(posedge CLK) begin
    if (RST) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (ist_rd ? int_stat_q & ~PRDATA[IRQ_W-1:0] : int_stat_q)
                    | ev;
    end
  end

  assign IRQ = |(int_stat_q & int_mask_q);

  // ****************************************************************
  // CTS synchroniser
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      cts_m_q <= 1'b0;
      cts_s_q <= 1'b0;
    end else begin
      cts_m_q <= CTS_I;
      cts_s_q <= cts_m_q;
    end
  end

  // ****************************************************************
  // Transmit sequencing
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_q      <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (tx_wr) begin
      pend_q      <= 1'b1;
      pend_data_q <= PWDATA[7:0];
    end else if (state_q == ST_SEND && !TXS_BUSY && !start_q) begin
      pend_q      <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      start_q  <= 1'b0;
      TXS_DATA <= 8'h00;
    end else begin
      start_q <= state_q == ST_SEND && pend_q && !TXS_BUSY && !start_q;
      if (state_q == ST_SEND && pend_q && !TXS_BUSY && !start_q) begin
        TXS_DATA <= pend_data_q;
      end
    end
  end
  assign TXS_START = start_q;

  sltc_ms_tick #(
    .DIV (MS_DIV)
  ) u_tick (
    .clk  (CLK),
    .rst  (RST),
    .clr  (hold_clr),
    .tick (ms_tick) // RULE14
  );

  assign hold_clr  = state_q != ST_HOLD;
  assign hold_done = hold_cnt_q >= hold_q;

  always_ff @(posedge CLK) begin
    if (RST || hold_clr) begin
      hold_cnt_q <= 16'h0000;
    end else if (ms_tick && !hold_done) begin
      hold_cnt_q <= hold_cnt_q + 16'h0001; // RULE5
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (pend_q) begin
          state_d = ST_ENGAGE;
        end
      end
      ST_ENGAGE: begin
        if (flow_q != FLOW_HW || cts_s_q) begin // RULE11 RULE12
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!pend_q && !TXS_BUSY && !start_q) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (pend_q) begin
          state_d = ST_ENGAGE; // RULE14
        end else if (hold_done) begin
          state_d = ST_IDLE; // RULE5
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign tx_done_p = state_q == ST_HOLD && !pend_q && hold_done; // RULE6

  // ****************************************************************
  // Line control outputs
  // ****************************************************************
  assign diff   = phys_q == PHYS_422 || phys_q == PHYS_485; // RULE15
  assign active = state_q != ST_IDLE;

  always_comb begin
    TXD_OE_N = 1'b1;
    if (diff && (duplex_q == DUPLEX_P2P || active)) begin
      TXD_OE_N = 1'b0; // RULE2 RULE3 RULE10
    end
  end
  assign RTS_OE_N = TXD_OE_N;
  assign RTS_O    = flow_q == FLOW_HW && active; // RULE11 RULE12
  assign RX_EN    = duplex_q != DUPLEX_HALF || !active; // RULE1 RULE4

  // ****************************************************************
  // Receive queue
  // ****************************************************************
  // Wrap at the configured size; one slot short by design of the count
  assign lim     = QPTR_W'(qsize_q - 15'h0001);
  assign q_full  = cnt_q == (qsize_q - 15'h0001); // RULE7
  assign q_empty = cnt_q == 15'h0000;
  assign pop     = rx_rd && !q_empty;
  assign push    = RXS_VALID && (!q_full || pop);
  assign ovf_ev  = RXS_VALID && q_full && !pop; // RULE8

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wp_q] <= RXS_DATA;
    end
  end

  // Resizing flushes the queue; stored data would straddle the wrap
  always_ff @(posedge CLK) begin
    if (RST || qsize_wr) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= 15'h0000;
    end else begin
      if (push) begin
        wp_q <= (wp_q == lim) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == lim) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + 15'(push) - 15'(pop);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  rx_full_dup_a: assert property (@(posedge CLK) disable iff (RST) // RULE1
    duplex_q == DUPLEX_FULL |-> RX_EN)
    else $error("receiver gated in full duplex");

  drv_on_a: assert property (@(posedge CLK) disable iff (RST) // RULE2
    diff && state_q == ST_SEND |-> !TXD_OE_N && !RTS_OE_N)
    else $error("drivers off while sending");

  drv_off_a: assert property (@(posedge CLK) disable iff (RST) // RULE3
    diff && duplex_q != DUPLEX_P2P && state_q == ST_IDLE
      |-> TXD_OE_N && RTS_OE_N)
    else $error("drivers on outside transmit");

  rx_half_a: assert property (@(posedge CLK) disable iff (RST) // RULE4
    duplex_q == DUPLEX_HALF && $rose(active) |-> !RX_EN)
    else $error("receiver on while sending half duplex");

  hold_zero_a: assert property (@(posedge CLK) disable iff (RST) // RULE5
    state_q == ST_HOLD && hold_q == 16'h0000 && !pend_q
      |=> state_q == ST_IDLE)
    else $error("zero hold did not end at once");

  done_late_a: assert property (@(posedge CLK) disable iff (RST) // RULE6
    tx_done_p |-> hold_cnt_q >= hold_q && !TXS_BUSY)
    else $error("completion before hold expiry");

  q_cap_a: assert property (@(posedge CLK) disable iff (RST) // RULE7
    cnt_q < qsize_q)
    else $error("queue over capacity");

  ovf_drop_a: assert property (@(posedge CLK) disable iff (RST) // RULE8
    ovf_ev && !qsize_wr |=> $stable(cnt_q) && int_stat_q[IRQ_RX_OVF])
    else $error("overflow character not dropped");

  size_rst_a: assert property (@(posedge CLK) // RULE9
    $fell(RST) |-> qsize_q == QSIZE_RST && duplex_q == DUPLEX_FULL)
    else $error("bad reset configuration");

  p2p_drv_a: assert property (@(posedge CLK) disable iff (RST) // RULE10
    duplex_q == DUPLEX_P2P && diff |-> !TXD_OE_N && RX_EN)
    else $error("point-to-point line state wrong");

  cts_wait_a: assert property (@(posedge CLK) disable iff (RST) // RULE11
    flow_q == FLOW_HW && state_q == ST_ENGAGE && !cts_s_q
      |=> state_q == ST_ENGAGE && RTS_O)
    else $error("sent before clear to send");

  no_rts_a: assert property (@(posedge CLK) disable iff (RST) // RULE12
    flow_q != FLOW_HW && state_q == ST_ENGAGE
      |-> !RTS_O ##1 state_q == ST_SEND)
    else $error("soft flow waited or raised RTS");

  hold_cancel_a: assert property (@(posedge CLK) disable iff (RST) // RULE14
    state_q == ST_HOLD && pend_q |=> state_q == ST_ENGAGE)
    else $error("new character did not cancel hold");

  rs232_a: assert property (@(posedge CLK) disable iff (RST) // RULE15
    phys_q == PHYS_232 |-> TXD_OE_N && RTS_OE_N)
    else $error("differential driver on in RS-232");
endmodule : sltc_top
`default_nettype wire

/* File: pkg/sltc_pkg.sv */
// Purpose: Shared constants for the serial line turnaround control block
// Assumes: 20 MHz system clock, APB register access
// Notes:   Register byte addresses, field codes and reset values
`default_nettype none
package sltc_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_HOLD     = 8'h04;
  localparam logic [7:0] ADDR_QSIZE    = 8'h08;
  localparam logic [7:0] ADDR_TXDATA   = 8'h0C;
  localparam logic [7:0] ADDR_RXDATA   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1C;

  // CTRL fields
  localparam int unsigned CTRL_DUPLEX_LSB = 0;
  localparam int unsigned CTRL_PHYS_LSB   = 2;
  localparam int unsigned CTRL_FLOW_LSB   = 4;

  // Wiring: full duplex (4 wire), half duplex (2 wire), point-to-point
  localparam logic [1:0] DUPLEX_FULL = 2'h0;
  localparam logic [1:0] DUPLEX_HALF = 2'h1;
  localparam logic [1:0] DUPLEX_P2P  = 2'h2;
  localparam logic [1:0] PHYS_232    = 2'h0;
  localparam logic [1:0] PHYS_422    = 2'h1;
  localparam logic [1:0] PHYS_485    = 2'h2;
  localparam logic [1:0] FLOW_HW     = 2'h0;
  localparam logic [1:0] FLOW_SW     = 2'h1;
  localparam logic [1:0] FLOW_NONE   = 2'h2;

  // Interrupt / status bit positions
  localparam int unsigned IRQ_TX_DONE = 0;
  localparam int unsigned IRQ_RX_CHAR = 1;
  localparam int unsigned IRQ_RX_OVF  = 2;
  localparam int unsigned IRQ_W       = 3;

  // ****************************************************************
  // Receive queue
  // ****************************************************************
  localparam int unsigned QPTR_W              = 10;
  localparam logic [14:0] QSIZE_MIN           = 15'h0040;
  localparam logic [14:0] QSIZE_MAX           = 15'h7FEE;
  localparam logic [14:0] QSIZE_STORE         = 15'h0400;
  localparam logic [14:0] QSIZE_RST           = 15'h0140;
  localparam logic [15:0] HOLD_RST            = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ENGAGE = 2'b01,
    ST_SEND   = 2'b11,
    ST_HOLD   = 2'b10
  } sltc_state_e;
endpackage : sltc_pkg
`default_nettype wire

/* File: design/sltc_ms_tick.sv */
// Purpose: Millisecond tick divider for the hold timer
// Assumes: DIV is at least 2
// Notes:   CLR restarts the period so a hold starts on a full interval
`default_nettype none
module sltc_ms_tick #(
  parameter int unsigned DIV = 20000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  output var  logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == 16'(DIV - 1));
    end
  end
endmodule : sltc_ms_tick
`default_nettype wire

/* File: verification/sltc_far_end.sv */
// Purpose: Far end model: character shifter, remote CTS and receive stream
// Assumes: Everything on the system clock, one character per request
// Notes:   Idle receive data toggles so stale values are never trusted
`default_nettype none
module sltc_far_end #(
  parameter int unsigned FRAME = 10
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       txs_start,
  input  wire logic [7:0] txs_data,
  output var  logic       txs_busy,
  output var  logic       rxs_valid,
  output var  logic [7:0] rxs_data,
  output var  logic       cts_i,
  input  wire logic       cts_req,
  input  wire logic       rx_req,
  input  wire logic [7:0] rx_char,
  output var  logic [7:0] last_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Shifter and line
  // ****************************************************************
  logic [7:0] cnt_q;

  // Busy rises the cycle after start and lasts one frame
  always_ff @(posedge clk) begin
    if (rst) begin
      txs_busy <= 1'b0;
      cnt_q    <= 8'h00;
      last_tx  <= 8'h00;
    end else if (txs_start) begin
      txs_busy <= 1'b1;
      cnt_q    <= FRAME[7:0];
      last_tx  <= txs_data;
    end else if (cnt_q != 8'h00) begin
      cnt_q    <= cnt_q - 8'h01;
      txs_busy <= (cnt_q != 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    cts_i     <= cts_req & ~rst;
    rxs_valid <= rx_req & ~rst;
    rxs_data  <= rx_req ? rx_char : ~rxs_data;
  end
endmodule : sltc_far_end
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the serial turnaround control block
// Assumes: Short millisecond divider, zero wait APB slave
// Notes:   Scenarios start right after a rising edge
`default_nettype none
module testbench;
  import sltc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    fail_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end

  localparam int unsigned DIV = 4;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdv;
  logic PREADY, PSLVERR, IRQ, TXS_START, TXS_BUSY, RXS_VALID, CTS_I;
  logic RTS_O, RTS_OE_N, TXD_OE_N, RX_EN, err;
  logic cts_req = 1'b0, rx_req = 1'b0;
  logic [7:0] TXS_DATA, RXS_DATA, last_tx, rx_char = 8'h00;
  int fail_count = 0, cmp_count = 0;

  always #25 CLK = ~CLK;

  sltc_top #(.MS_DIV(DIV)) DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .TXS_START(TXS_START), .TXS_DATA(TXS_DATA), .TXS_BUSY(TXS_BUSY),
    .RXS_VALID(RXS_VALID), .RXS_DATA(RXS_DATA), .CTS_I(CTS_I),
    .RTS_O(RTS_O), .RTS_OE_N(RTS_OE_N), .TXD_OE_N(TXD_OE_N), .RX_EN(RX_EN));

  sltc_far_end far (.clk(CLK), .rst(RST), .txs_start(TXS_START),
    .txs_data(TXS_DATA), .txs_busy(TXS_BUSY), .rxs_valid(RXS_VALID),
    .rxs_data(RXS_DATA), .cts_i(CTS_I), .cts_req(cts_req), .rx_req(rx_req),
    .rx_char(rx_char), .last_tx(last_tx));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Held until pready is seen high, released at that same edge, then one idle edge before returning
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("MISMATCH pready exp 1 got %0h", PREADY);
      report_and_stop();
    end
    rdv = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb

  task automatic wait_on(input bit irq_sel, input logic lvl);
    int n;
    n = 0;
    while ((irq_sel ? IRQ : TXS_BUSY) !== lvl) begin
      @(negedge CLK);
      n++;
      if (n > 3000) begin
        fail_count++;
        $display("MISMATCH wait exp %0h got %0h", lvl,
                 irq_sel ? IRQ : TXS_BUSY);
        report_and_stop();
      end
    end
  endtask : wait_on

  function automatic logic [31:0] cfg(logic [1:0] dx, logic [1:0] ph,
                                      logic [1:0] fl);
    return {26'h0, fl, ph, dx};
  endfunction : cfg

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge CLK);
    `CHK("rx_en", 1'b1, RX_EN)
    `CHK("oe", 2'b11, {RTS_OE_N, TXD_OE_N})
    `CHK("rts", 1'b0, RTS_O)
    @(posedge CLK);
    apb(1'b0, ADDR_HOLD, 32'h0);
    `CHK("hold", 32'h0, rdv)
    apb(1'b0, ADDR_QSIZE, 32'h0);
    `CHK("qsize", {17'h0, QSIZE_RST}, rdv)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("duplex", DUPLEX_FULL, rdv[1:0])
  endtask : t_reset

  task automatic t_half485();
    int n;
    apb(1'b1, ADDR_CTRL, cfg(DUPLEX_HALF, PHYS_485, FLOW_NONE));
    apb(1'b1, ADDR_HOLD, 32'h2);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    apb(1'b1, ADDR_TXDATA, 32'hA5);
    wait_on(1'b0, 1'b1);
    `CHK("rx_en", 1'b0, RX_EN)
    `CHK("oe", 2'b00, {RTS_OE_N, TXD_OE_N})
    `CHK("rts", 1'b0, RTS_O)
    wait_on(1'b0, 1'b0);
    `CHK("hold rx", 1'b0, RX_EN)
    `CHK("hold oe", 1'b0, TXD_OE_N)
    `CHK("early", 1'b0, IRQ)
    n = 0;
    while (IRQ !== 1'b1 && n < 100) begin
      @(negedge CLK);
      n++;
    end
    `CHK("hold len", 1'b1, n >= 2 * DIV && n <= 2 * DIV + 6)
    `CHK("char", 8'hA5, last_tx)
    @(posedge CLK);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    `CHK("done", 1'b1, rdv[IRQ_TX_DONE])
    @(negedge CLK);
    `CHK("rx back", 1'b1, RX_EN)
    `CHK("tristate", 2'b11, {RTS_OE_N, TXD_OE_N})
    `CHK("irq clr", 1'b0, IRQ)
    @(posedge CLK);
  endtask : t_half485

  task automatic t_full422_hw();
    apb(1'b1, ADDR_CTRL, cfg(DUPLEX_FULL, PHYS_422, FLOW_HW));
    apb(1'b1, ADDR_HOLD, 32'h0);
    apb(1'b1, ADDR_TXDATA, 32'h5A);
    repeat (8) @(negedge CLK);
    `CHK("no cts", 1'b0, TXS_BUSY)
    `CHK("rts on", 1'b1, RTS_O)
    `CHK("oe", 1'b0, RTS_OE_N)
    @(posedge CLK);
    cts_req <= 1'b1;
    wait_on(1'b0, 1'b1);
    `CHK("rx full", 1'b1, RX_EN)
    wait_on(1'b1, 1'b1);
    @(posedge CLK);
    cts_req <= 1'b0;
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    @(negedge CLK);
    `CHK("rts off", 1'b0, RTS_O)
    `CHK("tristate", 1'b1, RTS_OE_N)
    @(posedge CLK);
  endtask : t_full422_hw

  task automatic t_p2p_232();
    apb(1'b1, ADDR_CTRL, cfg(DUPLEX_P2P, PHYS_485, FLOW_NONE));
    @(negedge CLK);
    `CHK("p2p oe", 2'b00, {RTS_OE_N, TXD_OE_N})
    `CHK("p2p rx", 1'b1, RX_EN)
    @(posedge CLK);
    apb(1'b1, ADDR_CTRL, cfg(DUPLEX_HALF, PHYS_232, FLOW_SW));
    apb(1'b1, ADDR_TXDATA, 32'h3C);
    wait_on(1'b0, 1'b1);
    `CHK("232 oe", 2'b11, {RTS_OE_N, TXD_OE_N})
    `CHK("232 rx", 1'b0, RX_EN)
    wait_on(1'b1, 1'b1);
    @(posedge CLK);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
  endtask : t_p2p_232

  // Second character written while the hold runs cancels it
  task automatic t_cancel();
    apb(1'b1, ADDR_CTRL, cfg(DUPLEX_FULL, PHYS_422, FLOW_NONE));
    apb(1'b1, ADDR_HOLD, 32'h3);
    apb(1'b1, ADDR_TXDATA, 32'h96);
    wait_on(1'b0, 1'b1);
    wait_on(1'b0, 1'b0);
    @(posedge CLK);
    apb(1'b1, ADDR_TXDATA, 32'hC3);
    @(negedge CLK);
    `CHK("cancel oe", 2'b00, {RTS_OE_N, TXD_OE_N})
    wait_on(1'b0, 1'b1);
    `CHK("cancel irq", 1'b0, IRQ)
    `CHK("second", 8'hC3, last_tx)
    wait_on(1'b1, 1'b1);
    @(posedge CLK);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    `CHK("cancel done", 1'b1, rdv[IRQ_TX_DONE])
  endtask : t_cancel

  task automatic t_queue();
    apb(1'b1, ADDR_QSIZE, 32'hA);
    apb(1'b0, ADDR_QSIZE, 32'h0);
    `CHK("qmin", {17'h0, QSIZE_MIN}, rdv)
    apb(1'b1, ADDR_INT_MASK, 32'h4);
    for (int i = 0; i < 66; i++) begin
      rx_char <= 8'(i + 16);
      rx_req <= 1'b1;
      @(posedge CLK);
    end
    rx_req <= 1'b0;
    repeat (3) @(posedge CLK);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("count", 15'h003F, rdv[17:3])
    `CHK("ovf irq", 1'b1, IRQ)
    apb(1'b0, ADDR_RXDATA, 32'h0);
    `CHK("oldest", 32'h10, rdv)
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    `CHK("ovf flag", 1'b1, rdv[IRQ_RX_OVF])
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask : t_queue

  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_half485();
    t_full422_hw();
    t_p2p_232();
    t_cancel();
    t_queue();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
